// ===== bcu_cfg.svh
`ifndef BCU_CFG_SVH
`define BCU_CFG_SVH

// Register byte offsets on the APB slave.
`define BCU_OFS_CTRL 8'h00
`define BCU_OFS_AMOUNT 8'h04
`define BCU_OFS_FILT_TC 8'h08
`define BCU_OFS_STATUS 8'h0c
`define BCU_OFS_REF_CNT 8'h10
`define BCU_OFS_REF_SPEED 8'h14
`define BCU_OFS_DEVIATION 8'h18
`define BCU_OFS_FB_CNT 8'h1c
`define BCU_OFS_ACT_POS 8'h20
`define BCU_OFS_DEMAND_POS 8'h24
`define BCU_OFS_CUR_COMP 8'h28

// Field positions.
`define BCU_CTRL_DIR_BIT 0
`define BCU_STAT_COND_BIT 0
`define BCU_STAT_DIR_BIT 1
`define BCU_STAT_ACTIVE_BIT 2

// Reset values.
`define BCU_RST_DIR_SEL 1'h0
`define BCU_RST_AMOUNT 32'h0000_0000
`define BCU_RST_FILT_TC 16'h0000

// Backlash amount is held in tenths of a reference unit.
`define BCU_TENTHS_PER_UNIT 32'h0000_000a

// Control cycle length in the filter's own unit of 0.01 ms (0.25 ms).
`define BCU_CTRL_PERIOD_10US 16'h0019

`endif

// ===== bcu_pkg.sv
package bcu_pkg;

  typedef logic signed [31:0] bcu_pos_t;
  typedef logic [15:0] bcu_tc_t;
  typedef logic [7:0] bcu_addr_t;

  typedef enum logic [1:0] {
    BCU_APB_IDLE = 2'b01,
    BCU_APB_RESP = 2'b10
  } bcu_apb_st_t;

  typedef struct packed {
    bcu_apb_st_t apb;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic dir_sel;
    bcu_pos_t amount;
    bcu_tc_t tc;
    logic cond;
    logic dir_fwd;
    bcu_pos_t target;
    bcu_pos_t cmd;
    bcu_pos_t ref_cnt;
    bcu_pos_t ref_spd;
    bcu_pos_t motor;
    bcu_pos_t fb_cnt;
    bcu_pos_t pos_ref;
    logic vld1;
    logic pos_vld;
    bcu_pos_t enc_out;
  } bcu_main_st_t;

  typedef struct packed {
    bcu_pos_t y;
  } bcu_lag_st_t;

endpackage : bcu_pkg

// ===== bcu_lag.sv
`timescale 1ns/100ps
`default_nettype none
`include "bcu_cfg.svh"

module bcu_lag (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Filter control.
  input wire logic step,
  input wire logic flush,
  input wire bcu_pkg::bcu_pos_t target,
  input wire bcu_pkg::bcu_tc_t tc,
  // Filtered compensation.
  output bcu_pkg::bcu_pos_t y
);
  import bcu_pkg::*;

  bcu_lag_st_t st_q;
  bcu_lag_st_t st_d;
  logic signed [63:0] diff;
  logic signed [63:0] inc;

  // Integer lag can stall a step short of the target, so a step toward an unreached target is never less than one pulse.
  always_comb begin
    st_d = st_q;
    diff = 64'(target) - 64'(st_q.y);
    inc = (diff * $signed({48'h0000_0000_0000, `BCU_CTRL_PERIOD_10US}))
          / $signed({48'h0000_0000_0001, tc} & {48'h0000_0000_0000, 16'hffff} | 64'(tc == 16'h0000));
    if (inc == 64'sh0 && diff != 64'sh0) begin
      inc = diff > 64'sh0 ? 64'sh1 : -64'sh1;
    end
    if (flush) begin
      st_d.y = 32'sh0;
    end else if (step) begin
      if (tc <= `BCU_CTRL_PERIOD_10US) begin
        st_d.y = target;
      end else begin
        st_d.y = st_q.y + inc[31:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign y = st_q.y;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  filter_bypass_a: assert property (clk_en && step && !flush && tc == 16'h0000 |=> y == $past(target))
    else $error("Filter with zero time constant did not pass the target through.");

endmodule : bcu_lag

`default_nettype wire

// ===== bcu_top.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "bcu_cfg.svh"

// How it works
// - Add backlash in compensation direction while energised.
// - Opposite-direction references get no backlash added.
// - Actual position is shaft minus backlash.
// - Opposite direction: actual equals shaft position.
// - De-energised: drop compensation, shift demand by it.
// - Servo off: actual equals shaft, demand shifts by the dropped amount.
// - Overtravel behaves like servo off.
// - Compensate only in position control.
// - Entering position control resumes normal compensation.
// - Encoder output carries the driven backlash motion.
// - Reference counter and speed use uncompensated values.
// - Deviation uses the compensated position reference.
// - Feedback counter counts actually driven encoder pulses.
// - Direction select 0 forward, 1 reverse.
// - Amount in tenths, fraction dropped for pulses.
// - First order lag on amount, zero bypasses.
module bcu_top (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire bcu_pkg::bcu_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive state.
  input wire logic servo_on,
  input wire logic overtravel,
  input wire logic pos_ctrl_mode,
  // Reference from the host, one increment per control cycle.
  input wire logic ref_valid,
  input wire bcu_pkg::bcu_pos_t ref_delta,
  // Encoder feedback increment, sampled every enabled cycle.
  input wire bcu_pkg::bcu_pos_t fb_delta,
  // Toward the position loop and the divided encoder output.
  output bcu_pkg::bcu_pos_t pos_ref_out,
  output logic pos_ref_valid,
  output bcu_pkg::bcu_pos_t enc_out_delta
);
  import bcu_pkg::*;

  bcu_main_st_t st_q;
  bcu_main_st_t st_d;
  bcu_pos_t comp_y;
  logic cond_now;
  logic dir_new;
  logic dir_chg;
  logic flush;
  logic [3:0] sel_idx;
  logic [31:0] rd_val;

  function automatic logic [3:0] bcu_decode(input bcu_addr_t a);
    if (a == `BCU_OFS_CTRL) bcu_decode = 4'h0;
    else if (a == `BCU_OFS_AMOUNT) bcu_decode = 4'h1;
    else if (a == `BCU_OFS_FILT_TC) bcu_decode = 4'h2;
    else if (a == `BCU_OFS_STATUS) bcu_decode = 4'h3;
    else if (a == `BCU_OFS_REF_CNT) bcu_decode = 4'h4;
    else if (a == `BCU_OFS_REF_SPEED) bcu_decode = 4'h5;
    else if (a == `BCU_OFS_DEVIATION) bcu_decode = 4'h6;
    else if (a == `BCU_OFS_FB_CNT) bcu_decode = 4'h7;
    else if (a == `BCU_OFS_ACT_POS) bcu_decode = 4'h8;
    else if (a == `BCU_OFS_DEMAND_POS) bcu_decode = 4'h9;
    else if (a == `BCU_OFS_CUR_COMP) bcu_decode = 4'ha;
    else bcu_decode = 4'hf;
  endfunction : bcu_decode

  // Electronic gear is taken as 1:1; signed division truncates toward zero.
  function automatic bcu_pos_t bcu_to_pulses(input bcu_pos_t tenths);
    bcu_to_pulses = tenths / $signed(`BCU_TENTHS_PER_UNIT);
  endfunction : bcu_to_pulses

  bcu_lag u_lag (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .step(ref_valid),
    .flush(flush),
    .target(st_d.target),
    .tc(st_q.tc),
    .y(comp_y)
  );

  always_comb begin
    st_d = st_q;
    sel_idx = bcu_decode(paddr);
    rd_val = 32'h0000_0000;
    case (sel_idx)
      4'h0: rd_val = {31'h0000_0000, st_q.dir_sel};
      4'h1: rd_val = st_q.amount;
      4'h2: rd_val = {16'h0000, st_q.tc};
      4'h3: rd_val = {29'h0000_0000, comp_y != 32'sh0, st_q.dir_fwd, st_q.cond};
      4'h4: rd_val = st_q.ref_cnt;
      4'h5: rd_val = st_q.ref_spd;
      4'h6: rd_val = st_q.cmd + comp_y - st_q.motor;
      4'h7: rd_val = st_q.fb_cnt;
      4'h8: rd_val = st_q.motor - comp_y;
      4'h9: rd_val = st_q.cmd;
      4'ha: rd_val = comp_y;
      default: rd_val = 32'h0000_0000;
    endcase

    // Bus: the answer comes one cycle after the access phase opens.
    case (st_q.apb)
      BCU_APB_IDLE: begin
        if (psel && penable) begin
          st_d.apb = BCU_APB_RESP;
          st_d.pready = 1'b1;
          st_d.pslverr = sel_idx == 4'hf;
          st_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
        end
      end
      BCU_APB_RESP: begin
        st_d.apb = BCU_APB_IDLE;
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        if (psel && penable && pwrite && !st_q.pslverr) begin
          if (sel_idx == 4'h0) st_d.dir_sel = pwdata[`BCU_CTRL_DIR_BIT];
          else if (sel_idx == 4'h1) st_d.amount = pwdata;
          else if (sel_idx == 4'h2) st_d.tc = pwdata[15:0];
        end
      end
      default: begin
        st_d.apb = BCU_APB_IDLE;
        st_d.pready = 1'b0;
      end
    endcase

    // Control cycle.
    cond_now = servo_on && !overtravel && pos_ctrl_mode;
    dir_new = ref_delta != 32'sh0 ? ref_delta > 32'sh0 : st_q.dir_fwd;
    dir_chg = dir_new != st_q.dir_fwd || cond_now != st_q.cond;
    flush = ref_valid && !cond_now;
    st_d.vld1 = ref_valid;
    st_d.pos_vld = st_q.vld1;
    if (st_q.vld1) begin
      st_d.pos_ref = st_q.cmd + comp_y;
    end
    if (ref_valid) begin
      st_d.cond = cond_now;
      st_d.dir_fwd = dir_new;
      st_d.ref_cnt = st_q.ref_cnt + ref_delta;
      st_d.ref_spd = ref_delta;
      if (!cond_now) begin
        // Folding the held amount into the demand keeps the reference free of a jump.
        st_d.target = 32'sh0;
        st_d.cmd = st_q.cmd + ref_delta + comp_y;
      end else begin
        st_d.cmd = st_q.cmd + ref_delta;
        if (dir_chg) begin
          if (dir_new == !st_q.dir_sel) begin
            st_d.target = dir_new ? bcu_to_pulses(st_q.amount) : -bcu_to_pulses(st_q.amount);
          end else begin
            st_d.target = 32'sh0;
          end
        end
      end
    end
    st_d.motor = st_q.motor + fb_delta;
    st_d.fb_cnt = st_q.fb_cnt + fb_delta;
    st_d.enc_out = fb_delta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.apb <= BCU_APB_IDLE;
      st_q.dir_sel <= `BCU_RST_DIR_SEL;
      st_q.amount <= `BCU_RST_AMOUNT;
      st_q.tc <= `BCU_RST_FILT_TC;
      st_q.dir_fwd <= 1'b1;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign pos_ref_out = st_q.pos_ref;
  assign pos_ref_valid = st_q.pos_vld;
  assign enc_out_delta = st_q.enc_out;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_answer_a: assert property (clk_en && psel && penable && !pready |=> pready)
    else $error("APB access phase was not answered in one cycle.");

  ref_count_a: assert property (clk_en && ref_valid |=> st_q.ref_cnt == $past(st_q.ref_cnt) + $past(ref_delta))
    else $error("Reference counter did not track the uncompensated increment.");

  fb_count_a: assert property (clk_en |=> st_q.fb_cnt == $past(st_q.fb_cnt) + $past(fb_delta))
    else $error("Feedback counter missed driven encoder pulses.");

  servo_off_a: assert property (clk_en && ref_valid && !servo_on |=> comp_y == 32'sh0 && st_q.target == 32'sh0)
    else $error("Compensation survived a de-energised control cycle.");

  demand_shift_a: assert property (clk_en && ref_valid && !cond_now
                                   |=> st_q.cmd == $past(st_q.cmd) + $past(ref_delta) + $past(comp_y))
    else $error("Demand was not shifted by the withdrawn amount.");

  overtravel_off_a: assert property (clk_en && ref_valid && overtravel |=> !st_q.cond && comp_y == 32'sh0)
    else $error("Compensation applied during overtravel.");

  mode_off_a: assert property (clk_en && ref_valid && !pos_ctrl_mode |=> !st_q.cond && comp_y == 32'sh0)
    else $error("Compensation applied outside position control.");

  opposite_dir_a: assert property (clk_en && ref_valid && cond_now && ref_delta != 32'sh0
                                   && (ref_delta > 32'sh0) == st_q.dir_sel |=> st_q.target == 32'sh0)
    else $error("Backlash added to an opposite-direction reference.");

  dir_hold_a: assert property (clk_en && ref_valid && ref_delta == 32'sh0 && cond_now == st_q.cond
                               |=> $stable(st_q.target))
    else $error("Target changed without a direction change.");

  ref_out_a: assert property (clk_en && st_q.vld1 |=> pos_ref_valid && pos_ref_out == $past(st_q.cmd) + $past(comp_y))
    else $error("Position reference out is not demand plus compensation.");

  // A frozen cycle must leave every flop alone, the bus answer included.
  freeze_hold_a: assert property (!clk_en
                                  |=> st_q == $past(st_q))
    else $error("State moved while the clock enable was low.");

  ready_pulse_a: assert property (clk_en && pready
                                  |=> !pready)
    else $error("Bus answer stood for more than one cycle.");

  unmapped_err_a: assert property (clk_en && psel && penable && !pready && bcu_decode(paddr) == 4'hf
                                   |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("Unmapped access was not refused.");

  // Monitor reads must reflect the state of the cycle in which the access was taken.
  act_pos_read_a: assert property (clk_en && psel && penable && !pready && !pwrite && paddr == `BCU_OFS_ACT_POS
                                   |=> prdata == $past(st_q.motor - comp_y))
    else $error("Actual position read is not shaft minus compensation.");

  demand_read_a: assert property (clk_en && psel && penable && !pready && !pwrite && paddr == `BCU_OFS_DEMAND_POS
                                  |=> prdata == $past(st_q.cmd))
    else $error("Demand position read does not show the demand.");

  dev_read_a: assert property (clk_en && psel && penable && !pready && !pwrite && paddr == `BCU_OFS_DEVIATION
                               |=> prdata == $past(st_q.cmd + comp_y - st_q.motor))
    else $error("Deviation is not taken against the compensated reference.");

  // Condition latch, compensation target, reference and encoder output paths.
  cond_latch_a: assert property (clk_en && ref_valid
                                 |=> st_q.cond == $past(servo_on && !overtravel && pos_ctrl_mode))
    else $error("Compensation condition was not latched on the control cycle.");

  speed_copy_a: assert property (clk_en && ref_valid
                                 |=> st_q.ref_spd == $past(ref_delta))
    else $error("Reference speed is not the uncompensated increment.");

  pulse_trunc_a: assert property (clk_en && ref_valid && cond_now && dir_chg && dir_new == !st_q.dir_sel
                                  |=> st_q.target == ($past(dir_new) ? $past(st_q.amount) / 32'sh0000_000a
                                                      : -($past(st_q.amount) / 32'sh0000_000a)))
    else $error("Target is not the truncated amount in the selected direction.");

  pos_valid_a: assert property (clk_en && ref_valid ##1 clk_en
                                |=> pos_ref_valid)
    else $error("Position reference was not issued two cycles after the request.");

  enc_copy_a: assert property (clk_en
                               |=> enc_out_delta == $past(fb_delta))
    else $error("Encoder output does not carry the driven pulses.");

  comp_insert_c: cover property (clk_en && ref_valid && cond_now && dir_chg ##1 st_q.target != 32'sh0);
  servo_drop_c: cover property (st_q.cond && comp_y != 32'sh0 ##1 clk_en && ref_valid && !servo_on);
  apb_write_c: cover property (clk_en && psel && penable && pwrite && pready);
  filter_lag_c: cover property (clk_en && ref_valid && cond_now && st_q.tc > `BCU_CTRL_PERIOD_10US ##1 comp_y != st_q.target);
  freeze_c: cover property (!clk_en ##1 clk_en);

endmodule : bcu_top

`default_nettype wire

// ===== bcu_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module bcu_host_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Request from the test sequence.
  input wire logic go,
  input wire logic [3:0] gap,
  input wire bcu_pkg::bcu_pos_t delta,
  // Reference link.
  output logic ref_valid,
  output bcu_pkg::bcu_pos_t ref_delta
);
  import bcu_pkg::*;
  logic [3:0] wait_q;
  logic pend_q;
  bcu_pos_t hold_q;

  // Outside a pulse the increment is inverted every cycle, so a late sample cannot match by chance.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_valid <= 1'b0;
      ref_delta <= 32'h5a5a_5a5a;
      wait_q <= 4'h0;
      pend_q <= 1'b0;
      hold_q <= 32'h0000_0000;
    end else begin
      ref_valid <= 1'b0;
      ref_delta <= ~ref_delta;
      if (go) begin
        pend_q <= 1'b1;
        wait_q <= gap;
        hold_q <= delta;
      end else if (pend_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (pend_q) begin
        pend_q <= 1'b0;
        ref_valid <= 1'b1;
        ref_delta <= hold_q;
      end
    end
  end
endmodule : bcu_host_model

`default_nettype wire

// ===== bcu_top_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "bcu_cfg.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module bcu_top_test;
  import bcu_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  bcu_addr_t paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, servo_on = 1'b1, overtravel = 1'b0, pos_ctrl_mode = 1'b1;
  logic ref_valid, pos_ref_valid, go = 1'b0, clk_en = 1'b1;
  logic [3:0] gap = 4'h0;
  bcu_pos_t ref_delta, pos_ref_out, enc_out_delta, dly = 32'h0000_0000, fb_delta = 32'h0000_0000;
  int err_count = 0, num_checks = 0, cyc = 0;

  always #25 pclk = ~pclk;

  bcu_top bcu_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .servo_on(servo_on), .overtravel(overtravel), .pos_ctrl_mode(pos_ctrl_mode), .ref_valid(ref_valid),
    .ref_delta(ref_delta), .fb_delta(fb_delta), .pos_ref_out(pos_ref_out), .pos_ref_valid(pos_ref_valid),
    .enc_out_delta(enc_out_delta));

  bcu_host_model bcu_host_model_i (.pclk(pclk), .presetn(presetn), .go(go), .gap(gap), .delta(dly),
    .ref_valid(ref_valid), .ref_delta(ref_delta));

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // A hang is caught at 20000 cycles, far above the whole sequence, which needs well under 2000.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic apb(input logic wr, input bcu_addr_t a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input bcu_addr_t a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("read data", ex, rd)
    `CHK("read error", 1'b0, er)
  endtask : rchk

  task automatic send(input bcu_pos_t d);
    @(posedge pclk);
    go <= 1'b1;
    dly <= d;
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(negedge pclk);
    end while (pos_ref_valid !== 1'b1);
    // Return on a rising edge so that the next stimulus is launched there.
    @(posedge pclk);
  endtask : send

  task automatic sref(input bcu_pos_t d, input bcu_pos_t ex);
    send(d);
    `CHK("pos_ref_out", ex, pos_ref_out)
  endtask : sref

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`BCU_OFS_CTRL, 32'h0000_0000);
    rchk(`BCU_OFS_AMOUNT, 32'h0000_0000);
    rchk(`BCU_OFS_FILT_TC, 32'h0000_0000);
    apb(1'b1, `BCU_OFS_STATUS, 32'hffff_ffff);
    rchk(`BCU_OFS_STATUS, 32'h0000_0002);
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, er)
    `CHK("unmapped data", 32'h0000_0000, rd)
    apb(1'b1, `BCU_OFS_AMOUNT, 32'h0000_0041);
    @(posedge pclk) fb_delta <= 32'h0000_0007;
    @(posedge pclk) fb_delta <= 32'h0000_0000;
    @(negedge pclk) `CHK("enc_out_delta", 32'h0000_0007, enc_out_delta)
    rchk(`BCU_OFS_FB_CNT, 32'h0000_0007);
    // Pulses offered while the enable is low must not be counted.
    clk_en <= 1'b0;
    fb_delta <= 32'h0000_0003;
    repeat (2) @(posedge pclk);
    clk_en <= 1'b1;
    fb_delta <= 32'h0000_0000;
    rchk(`BCU_OFS_FB_CNT, 32'h0000_0007);
    sref(32'h0000_0064, 32'h0000_006a);
    rchk(`BCU_OFS_REF_CNT, 32'h0000_0064);
    rchk(`BCU_OFS_REF_SPEED, 32'h0000_0064);
    rchk(`BCU_OFS_DEVIATION, 32'h0000_0063);
    rchk(`BCU_OFS_ACT_POS, 32'h0000_0001);
    gap <= 4'h5;
    sref(-32'sd50, 32'h0000_0032);
    gap <= 4'h0;
    rchk(`BCU_OFS_ACT_POS, 32'h0000_0007);
    sref(-32'sd10, 32'h0000_0028);
    sref(32'h0000_0014, 32'h0000_0042);
    servo_on <= 1'b0;
    sref(32'h0000_0000, 32'h0000_0042);
    rchk(`BCU_OFS_DEMAND_POS, 32'h0000_0042);
    rchk(`BCU_OFS_CUR_COMP, 32'h0000_0000);
    servo_on <= 1'b1;
    sref(32'h0000_0000, 32'h0000_0048);
    overtravel <= 1'b1;
    sref(32'h0000_0000, 32'h0000_0048);
    rchk(`BCU_OFS_DEMAND_POS, 32'h0000_0048);
    overtravel <= 1'b0;
    sref(32'h0000_0000, 32'h0000_004e);
    pos_ctrl_mode <= 1'b0;
    sref(32'h0000_0000, 32'h0000_004e);
    rchk(`BCU_OFS_CUR_COMP, 32'h0000_0000);
    pos_ctrl_mode <= 1'b1;
    sref(32'h0000_0000, 32'h0000_0054);
    servo_on <= 1'b0;
    sref(32'h0000_0000, 32'h0000_0054);
    apb(1'b1, `BCU_OFS_CTRL, 32'h0000_0001);
    servo_on <= 1'b1;
    sref(-32'sd30, 32'h0000_0030);
    sref(32'h0000_000a, 32'h0000_0040);
    apb(1'b1, `BCU_OFS_FILT_TC, 32'h0000_0064);
    // Lag of -6 pulses over 100 units moves 6*25/100, truncated to 1 pulse, on the first step.
    sref(-32'sd5, 32'h0000_003a);
    repeat (8) send(32'h0000_0000);
    `CHK("settled output", 32'h0000_0035, pos_ref_out)
    rchk(`BCU_OFS_CUR_COMP, 32'hffff_fffa);
    tally_and_finish();
  end
endmodule : bcu_top_test

`default_nettype wire
